// ==== rtl/wcfu_pkg.sv ====
// package of constants and types for the word compare flag unit
package wcfu_pkg;
  // special relay bit addresses of the result flags
  localparam int unsigned GREATER_FLAG_ADDR = 25505;
  localparam int unsigned EQUAL_FLAG_ADDR   = 25506;
  localparam int unsigned LESS_FLAG_ADDR    = 25507;
  // APB register byte offsets
  localparam logic [7:0] OFS_OPA_LO = 8'h00;
  localparam logic [7:0] OFS_OPA_HI = 8'h04;
  localparam logic [7:0] OFS_OPB_LO = 8'h08;
  localparam logic [7:0] OFS_OPB_HI = 8'h0c;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_FLAGS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST = 8'h18;
  localparam logic [7:0] OFS_IRQ_MK = 8'h1c;
  localparam logic [7:0] OFS_PTR    = 8'h20;
  // command bit positions
  localparam int unsigned CMD_WORD_BIT   = 0;
  localparam int unsigned CMD_DOUBLE_BIT = 1;
  localparam int unsigned CMD_INDIR_BIT  = 2;
  // event bit positions in status and mask
  localparam int unsigned EV_DONE_BIT = 0;
  localparam int unsigned EV_ERR_BIT  = 1;
  // data memory size in words (pointer must be below this)
  localparam logic [15:0] DM_WORDS = 16'h1770;
  // first pointer value past data memory, as four bcd digits
  localparam logic [15:0] DM_LIMIT_BCD = 16'h6000;
  // reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [1:0]  RST_EV    = 2'h0;
  // result flags as carried together
  typedef struct packed {
    logic less_flag;
    logic equal_flag;
    logic greater_flag;
  } wcfu_flags_t;
  localparam wcfu_flags_t RST_FLAGS = '{less_flag: 1'b0, equal_flag: 1'b0, greater_flag: 1'b0};
endpackage

// ==== rtl/wcfu_top.sv ====
// word and double-word compare unit with APB register access
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module wcfu_top
  import wcfu_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // result flags and interrupt
  output logic             greater_flag,
  output logic             equal_flag,
  output logic             less_flag,
  output logic             error_flag,
  output logic             irq
);

  // operands, pointer, flags, events
  logic [15:0] opa_lo_r, opa_hi_r, opb_lo_r, opb_hi_r, ptr_r;
  wcfu_flags_t flags_r, flags_nxt;
  logic        err_r, err_nxt;
  logic [1:0]  ev_st_r, ev_st_nxt, ev_mk_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pslverr_r, irq_r;

  // unsigned magnitude compare giving one-hot flags
  function automatic wcfu_flags_t cmp32(input logic [31:0] a, input logic [31:0] b);
    cmp32.greater_flag = (a > b);
    cmp32.equal_flag   = (a == b);
    cmp32.less_flag    = (a < b);
  endfunction

  // one bcd digit out of range
  function automatic logic digit_bad(input logic [3:0] d);
    digit_bad = (d > 4'h9);
  endfunction

  // pointer must be four bcd digits and inside data memory
  function automatic logic ptr_bad(input logic [15:0] p);
    logic nonbcd;
    nonbcd = digit_bad(p[3:0]) || digit_bad(p[7:4]) || digit_bad(p[11:8]) || digit_bad(p[15:12]);
    ptr_bad = nonbcd || (p >= DM_LIMIT_BCD);
  endfunction

  // bus decode
  wire acc       = psel & penable & ~pready_r;
  wire wr        = acc & pwrite;
  wire rd        = acc & ~pwrite;
  wire hit_cmd   = (paddr == OFS_CMD);
  wire mapped    = (paddr == OFS_OPA_LO) | (paddr == OFS_OPA_HI) | (paddr == OFS_OPB_LO) |
                   (paddr == OFS_OPB_HI) | hit_cmd | (paddr == OFS_FLAGS) |
                   (paddr == OFS_IRQ_ST) | (paddr == OFS_IRQ_MK) | (paddr == OFS_PTR);
  wire do_word   = wr & hit_cmd & pwdata[CMD_WORD_BIT];
  wire do_double = wr & hit_cmd & pwdata[CMD_DOUBLE_BIT] & ~pwdata[CMD_WORD_BIT];
  wire indir     = pwdata[CMD_INDIR_BIT];
  wire bad_ptr   = indir & ptr_bad(ptr_r);
  wire run       = do_word | do_double;

  // operand formation: word compare uses low words zero extended
  wire [31:0] val_a = do_double ? {opa_hi_r, opa_lo_r} : {16'h0000, opa_lo_r};
  wire [31:0] val_b = do_double ? {opb_hi_r, opb_lo_r} : {16'h0000, opb_lo_r};
  wire wcfu_flags_t res = cmp32(val_a, val_b);

  // flags change only on an executed compare
  always_comb begin
    flags_nxt = flags_r;
    err_nxt   = err_r;
    if (run) begin
      err_nxt = bad_ptr;
      if (!bad_ptr) begin
        flags_nxt = res;
      end
    end
  end

  // sticky events, set beats write-one clear
  always_comb begin
    ev_st_nxt = ev_st_r;
    if (wr && paddr == OFS_IRQ_ST) begin
      ev_st_nxt = ev_st_r & ~pwdata[1:0];
    end
    ev_st_nxt[EV_DONE_BIT] = ev_st_nxt[EV_DONE_BIT] | (run & ~bad_ptr);
    ev_st_nxt[EV_ERR_BIT]  = ev_st_nxt[EV_ERR_BIT] | (run & bad_ptr);
  end

  // read mux
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    unique case (paddr)
      OFS_OPA_LO: prdata_nxt = {16'h0000, opa_lo_r};
      OFS_OPA_HI: prdata_nxt = {16'h0000, opa_hi_r};
      OFS_OPB_LO: prdata_nxt = {16'h0000, opb_lo_r};
      OFS_OPB_HI: prdata_nxt = {16'h0000, opb_hi_r};
      OFS_FLAGS:  prdata_nxt = {28'h000_0000, err_r, flags_r};
      OFS_IRQ_ST: prdata_nxt = {30'h0000_0000, ev_st_r};
      OFS_IRQ_MK: prdata_nxt = {30'h0000_0000, ev_mk_r};
      OFS_PTR:    prdata_nxt = {16'h0000, ptr_r};
      default:    prdata_nxt = 32'h0000_0000;
    endcase
  end

  // operand and config registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      opa_lo_r <= RST_WORD;
      opa_hi_r <= RST_WORD;
      opb_lo_r <= RST_WORD;
      opb_hi_r <= RST_WORD;
      ptr_r    <= RST_WORD;
      ev_mk_r  <= RST_EV;
    end else if (wr) begin
      if (paddr == OFS_OPA_LO) opa_lo_r <= pwdata[15:0];
      if (paddr == OFS_OPA_HI) opa_hi_r <= pwdata[15:0];
      if (paddr == OFS_OPB_LO) opb_lo_r <= pwdata[15:0];
      if (paddr == OFS_OPB_HI) opb_hi_r <= pwdata[15:0];
      if (paddr == OFS_PTR)    ptr_r    <= pwdata[15:0];
      if (paddr == OFS_IRQ_MK) ev_mk_r  <= pwdata[1:0];
    end
  end

  // result, event and bus response registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flags_r   <= RST_FLAGS;
      err_r     <= 1'b0;
      ev_st_r   <= RST_EV;
      irq_r     <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      flags_r   <= flags_nxt;
      err_r     <= err_nxt;
      ev_st_r   <= ev_st_nxt;
      irq_r     <= |(ev_st_nxt & ev_mk_r);
      prdata_r  <= rd ? prdata_nxt : 32'h0000_0000;
      pready_r  <= acc;
      pslverr_r <= acc & ~mapped;
    end
  end

  // outputs straight from flops
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign greater_flag = flags_r.greater_flag;
  assign equal_flag   = flags_r.equal_flag;
  assign less_flag    = flags_r.less_flag;
  assign error_flag   = err_r;
  assign irq          = irq_r;

  // checks: flags hold without an executed compare
  a_flags_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !run
    |=> $stable(flags_r))
    else $error("flags changed without compare");
  a_double_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !do_double && !do_word
    |=> flags_r == $past(flags_r))
    else $error("double hold");
  a_read_silent: assert property (@(posedge sys_clk) disable iff (reset)
    rd
    |=> $stable(flags_r))
    else $error("read changed flags");
  a_flags_cause: assert property (@(posedge sys_clk) disable iff (reset)
    !$stable(flags_r)
    |-> $past(run) && !$past(bad_ptr))
    else $error("flags changed with no executed compare");

  // checks: one-hot flags after any executed compare, then word compare outcome
  a_one_hot: assert property (@(posedge sys_clk) disable iff (reset)
    run && !bad_ptr
    |=> $onehot(flags_r))
    else $error("flags not one-hot");
  a_greater_ok: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r > opb_lo_r
    |=> greater_flag)
    else $error("greater");
  a_greater_clear: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r <= opb_lo_r
    |=> !greater_flag)
    else $error("greater flag without greater operand");
  a_equal_ok: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr
    |=> equal_flag == ($past(opa_lo_r) == $past(opb_lo_r)))
    else $error("equal");
  a_equal_clear: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r != opb_lo_r
    |=> !equal_flag)
    else $error("equal flag on differing words");
  a_less_ok: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r < opb_lo_r
    |=> less_flag)
    else $error("less");
  a_less_clear: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r >= opb_lo_r
    |=> !less_flag)
    else $error("less flag without smaller operand");
  a_word_low_only: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r == opb_lo_r && opa_hi_r != opb_hi_r
    |=> equal_flag)
    else $error("word compare looked at upper words");
  a_word_wins: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && pwdata[CMD_DOUBLE_BIT] && !bad_ptr && opa_lo_r < opb_lo_r
    |=> less_flag)
    else $error("word compare lost to double");
  a_unsigned_cmp: assert property (@(posedge sys_clk) disable iff (reset)
    do_word && !bad_ptr && opa_lo_r[15] && !opb_lo_r[15]
    |=> greater_flag)
    else $error("signed compare");

  // checks: double compare outcome
  a_double_cmp: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && {opa_hi_r, opa_lo_r} < {opb_hi_r, opb_lo_r}
    |=> less_flag)
    else $error("double less");
  a_double_greater: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && {opa_hi_r, opa_lo_r} > {opb_hi_r, opb_lo_r}
    |=> greater_flag)
    else $error("double greater");
  a_double_equal: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && {opa_hi_r, opa_lo_r} == {opb_hi_r, opb_lo_r}
    |=> equal_flag)
    else $error("double equal");
  a_dbl_less_clear: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && {opa_hi_r, opa_lo_r} >= {opb_hi_r, opb_lo_r}
    |=> !less_flag)
    else $error("double less flag wrongly set");
  a_dbl_grt_clear: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && {opa_hi_r, opa_lo_r} <= {opb_hi_r, opb_lo_r}
    |=> !greater_flag)
    else $error("double greater flag wrongly set");
  a_dbl_eq_clear: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && {opa_hi_r, opa_lo_r} != {opb_hi_r, opb_lo_r}
    |=> !equal_flag)
    else $error("double equal flag wrongly set");
  a_double_upper: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && opa_hi_r > opb_hi_r
    |=> greater_flag)
    else $error("upper word does not dominate");
  a_double_lower: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && opa_hi_r == opb_hi_r && opa_lo_r < opb_lo_r
    |=> less_flag)
    else $error("lower word ignored on equal upper");
  a_dbl_unsigned: assert property (@(posedge sys_clk) disable iff (reset)
    do_double && !bad_ptr && opa_hi_r[15] && !opb_hi_r[15]
    |=> greater_flag)
    else $error("double compare took a sign");

  // checks: pointer error flag
  a_error_set: assert property (@(posedge sys_clk) disable iff (reset)
    run && bad_ptr
    |=> error_flag && $stable(flags_r))
    else $error("error flag");
  a_error_clear: assert property (@(posedge sys_clk) disable iff (reset)
    run && !bad_ptr
    |=> !error_flag)
    else $error("error flag left after good compare");
  a_error_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !run
    |=> $stable(error_flag))
    else $error("error flag moved without compare");
  a_nonbcd_ptr: assert property (@(posedge sys_clk) disable iff (reset)
    run && indir && ptr_r[3:0] > 4'h9
    |=> error_flag)
    else $error("non-bcd pointer accepted");
  a_ptr_limit: assert property (@(posedge sys_clk) disable iff (reset)
    run && indir && ptr_r >= DM_LIMIT_BCD
    |=> error_flag)
    else $error("pointer past data memory accepted");
  a_no_indir: assert property (@(posedge sys_clk) disable iff (reset)
    run && !indir
    |=> !error_flag)
    else $error("error flag without pointer check");

  // checks: events and interrupt
  a_done_event: assert property (@(posedge sys_clk) disable iff (reset)
    run && !bad_ptr
    |=> ev_st_r[EV_DONE_BIT])
    else $error("done event missing");
  a_err_event: assert property (@(posedge sys_clk) disable iff (reset)
    run && bad_ptr
    |=> ev_st_r[EV_ERR_BIT])
    else $error("error event missing");
  a_w1c_clear: assert property (@(posedge sys_clk) disable iff (reset)
    wr && paddr == OFS_IRQ_ST && pwdata[EV_DONE_BIT]
    |=> !ev_st_r[EV_DONE_BIT])
    else $error("done event not cleared");
  a_status_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    ev_st_r[EV_DONE_BIT] && !(wr && paddr == OFS_IRQ_ST)
    |=> ev_st_r[EV_DONE_BIT])
    else $error("done event lost");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1
    |=> irq == |($past(ev_st_nxt) & $past(ev_mk_r)))
    else $error("irq");

  // checks: register bus
  a_pready_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    pready
    |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_follows: assert property (@(posedge sys_clk) disable iff (reset)
    psel && penable && !pready
    |=> pready)
    else $error("access not answered");
  a_slverr_rdy: assert property (@(posedge sys_clk) disable iff (reset)
    pslverr
    |-> pready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !pready
    |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_unmapped_err: assert property (@(posedge sys_clk) disable iff (reset)
    acc && !mapped
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (@(posedge sys_clk) disable iff (reset)
    acc && mapped
    |=> !pslverr)
    else $error("mapped access refused");
  a_opa_write: assert property (@(posedge sys_clk) disable iff (reset)
    wr && paddr == OFS_OPA_LO
    |=> opa_lo_r == $past(pwdata[15:0]))
    else $error("operand write lost");
  a_opb_write: assert property (@(posedge sys_clk) disable iff (reset)
    wr && paddr == OFS_OPB_HI
    |=> opb_hi_r == $past(pwdata[15:0]))
    else $error("upper operand write lost");
  a_mask_write: assert property (@(posedge sys_clk) disable iff (reset)
    wr && paddr == OFS_IRQ_MK
    |=> ev_mk_r == $past(pwdata[1:0]))
    else $error("mask write lost");
  a_read_ptr: assert property (@(posedge sys_clk) disable iff (reset)
    rd && paddr == OFS_PTR
    |=> prdata == {16'h0000, $past(ptr_r)})
    else $error("pointer read wrong");

  // main scenarios reached
  c_word_run: cover property (@(posedge sys_clk) do_word && !bad_ptr);
  c_double_run: cover property (@(posedge sys_clk) do_double && !bad_ptr);
  c_double_eq: cover property (@(posedge sys_clk) do_double && !bad_ptr && res.equal_flag);
  c_bad_ptr: cover property (@(posedge sys_clk) run && bad_ptr);
  c_irq: cover property (@(posedge sys_clk) $rose(irq));

endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the word compare flag unit
`timescale 1ns/1ps
module tb_top;
  import wcfu_pkg::*;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic        greater_flag, equal_flag, less_flag, error_flag, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, a, b, cmd;
  logic [15:0] ptrs [5];
  int          n_fail, n_tests;
  wcfu_flags_t ef;
  // device under test
  wcfu_top u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .greater_flag(greater_flag), .equal_flag(equal_flag),
    .less_flag(less_flag), .error_flag(error_flag), .irq(irq));
  // 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // unsigned magnitude outcome as one-hot flags
  function automatic wcfu_flags_t cmp_exp(input logic [31:0] x, input logic [31:0] y);
    return '{less_flag: x < y, equal_flag: x == y, greater_flag: x > y};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, held until pready, then released
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    seed = 32'h6308_299e;
    ptrs = '{16'h00a0, 16'h5999, 16'h6000, 16'h0000, 16'h12f4};
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    apb(0, OFS_FLAGS, 0);
    check(rd, 0);
    check({less_flag, equal_flag, greater_flag, error_flag, irq}, 0);
    apb(1, 8'h40, 32'h1);
    check(er, 1);
    apb(0, 8'h40, 0);
    check(er, 1);
    check(rd, 0);
    apb(1, OFS_IRQ_MK, 32'h1);
    // random and corner compares, word and double
    for (int k = 0; k < 40; k++) begin
      a = rnd();
      b = (k % 3 == 0) ? a : rnd();
      if (k % 4 == 1) b[31:16] = a[31:16];
      if (k == 2) {a, b} = {32'h0, 32'hffff_ffff};
      if (k == 5) {a, b} = {32'h8000_8000, 32'h0001_0001};
      if (k == 7) {a, b} = {32'h0000_4000, 32'h0000_3000};
      cmd = (k % 2) ? 32'h2 : ((k % 7 == 4) ? 32'h3 : 32'h1);
      apb(1, OFS_OPA_LO, {16'h0, a[15:0]});
      apb(1, OFS_OPA_HI, {16'h0, a[31:16]});
      apb(1, OFS_OPB_LO, {16'h0, b[15:0]});
      apb(1, OFS_OPB_HI, {16'h0, b[31:16]});
      apb(1, OFS_CMD, cmd);
      ef = (k % 2) ? cmp_exp(a, b) : cmp_exp({16'h0, a[15:0]}, {16'h0, b[15:0]});
      apb(0, OFS_FLAGS, 0);
      check(rd, {28'h0, 1'b0, ef});
      check({less_flag, equal_flag, greater_flag, error_flag}, {ef, 1'b0});
      check(irq, 1);
      apb(1, OFS_OPA_LO, {16'h0, ~a[15:0]});
      apb(1, OFS_CMD, 0);
      check({less_flag, equal_flag, greater_flag}, ef);
    end
    apb(1, OFS_IRQ_ST, 32'h3);
    apb(0, OFS_IRQ_ST, 0);
    check(rd, 0);
    check(irq, 0);
    apb(1, OFS_IRQ_MK, 32'h2);
    // indirect pointer checks, bad pointers leave flags alone
    for (int k = 0; k < 5; k++) begin
      apb(1, OFS_PTR, {16'h0, ptrs[k]});
      apb(1, OFS_CMD, 32'h5);
      if (k % 2 == 1) ef = cmp_exp({16'h0, ~a[15:0]}, {16'h0, b[15:0]});
      apb(0, OFS_FLAGS, 0);
      check(rd, {28'h0, k % 2 == 0, ef});
    end
    apb(0, OFS_IRQ_ST, 0);
    check({rd[1], irq}, 2'b11);
    end_of_test();
  end
endmodule
